// ===== include/tpp_consts.svh
// Register indices, field positions and reset values of the timer control block.
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH
`define TPP_IDX_W 6
`define TPP_IDX_SHORT_CTRL 6'h00
`define TPP_IDX_AUX_CTRL 6'h01
`define TPP_IDX_LONG_CTRL 6'h02
`define TPP_IDX_SHORT_RELOAD 6'h04
`define TPP_IDX_LONG_RELOAD 6'h05
`define TPP_IDX_COUNT 6'h06
`define TPP_BIT_RUN 7
`define TPP_BIT_SINGLE 6
`define TPP_BIT_TOUT 5
`define TPP_BIT_PRE_HI 4
`define TPP_BIT_PRE_LO 3
`define TPP_BIT_CAPM 2
`define TPP_BIT_PP_LO 2
`define TPP_BIT_PP_HI 3
`define TPP_RST_BYTE 8'h00
`define TPP_RST_WORD 16'h0000
`define TPP_RST_BUS 32'h0000_0000
`define TPP_PRE_DIV1 2'h0
`define TPP_DIV_W 3
`endif

// ===== include/tpp_pkg.sv
// Types shared by the timer control block.
package tpp_pkg;
    typedef struct packed {
        logic run;
        logic single;
        logic [1:0] presc;
        logic cap_mask;
    } tpp_ctrl_s;
endpackage : tpp_pkg

// ===== core/tpp_prescale.sv
// Prescaler that turns the system clock into a count tick of 1, 2, 4 or 8 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_prescale
    import tpp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [`TPP_DIV_W-1:0] div_q;
    logic [`TPP_DIV_W-1:0] div_d;
    logic [`TPP_DIV_W-1:0] mask;

    always_comb begin
        div_d = div_q + 3'h1;
        mask = 3'((4'h1 << sel) - 4'h1);
        tick = ((div_q & mask) == 3'h0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end

    a_div_period: assert property (@(posedge clk) disable iff (rst)
        (tick && sel == 2'h3 && $stable(sel)) |-> ##1 (!tick || sel != 2'h3) [*7])
        else $error("prescale divide by 8 ticked early");
endmodule : tpp_prescale
`default_nettype wire

// ===== core/tpp_count.sv
// Reloading down-counter that flags its terminal count.
`timescale 1ns/10ps
`default_nettype none
module tpp_count #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic [W-1:0] reload,
    output logic [W-1:0] count,
    output logic tc
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    always_comb begin
        tc = run && tick && (count_q == '0);
        count_d = count_q;
        if (!run) begin
            count_d = reload;
        end else if (tc) begin
            count_d = reload;
        end else if (tick) begin
            count_d = count_q - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;
endmodule : tpp_count
`default_nettype wire

// ===== core/tpp_timer_ctrl.sv
// Control of the short and long counters with ping-pong alternation and an APB slave.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_timer_ctrl
    import tpp_pkg::*;
#(
    parameter int SHORT_W = 8,
    parameter int LONG_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_event,
    output logic capture_irq,
    output logic short_timeout_pulse,
    output logic long_timeout_pulse
);
    tpp_ctrl_s s_ctrl_q, s_ctrl_d, l_ctrl_q, l_ctrl_d;
    logic s_tout_q, s_tout_d, l_tout_q, l_tout_d;
    logic [7:0] aux_q, aux_d;
    logic [SHORT_W-1:0] s_reload_q, s_reload_d;
    logic [LONG_W-1:0] l_reload_q, l_reload_d;
    logic [31:0] prdata_q, prdata_d;
    logic irq_q, irq_d;
    logic s_tick, l_tick, s_tc, l_tc;
    logic [SHORT_W-1:0] s_count;
    logic [LONG_W-1:0] l_count;
    logic [`TPP_IDX_W-1:0] idx;
    logic mapped, setup, wr;
    logic wr_s, wr_l, wr_aux;
    logic ping_pong;

    // Bus decode: every index is one aligned word.
    always_comb begin
        idx = paddr[7:2];
        mapped = (idx == `TPP_IDX_SHORT_CTRL) || (idx == `TPP_IDX_AUX_CTRL) ||
                 (idx == `TPP_IDX_LONG_CTRL) || (idx == `TPP_IDX_SHORT_RELOAD) ||
                 (idx == `TPP_IDX_LONG_RELOAD) || (idx == `TPP_IDX_COUNT);
        setup = psel && !penable;
        wr = psel && penable && pwrite && mapped;
        wr_s = wr && (idx == `TPP_IDX_SHORT_CTRL);
        wr_l = wr && (idx == `TPP_IDX_LONG_CTRL);
        wr_aux = wr && (idx == `TPP_IDX_AUX_CTRL);
        pready = psel && penable;
        pslverr = psel && penable && !mapped;
        ping_pong = aux_q[`TPP_BIT_PP_HI] && aux_q[`TPP_BIT_PP_LO];
    end

    // Ticks are never gated by a processor halt, so the counters keep going.
    tpp_prescale u_s_pre (
        .clk(clk),
        .rst(rst),
        .sel(s_ctrl_q.presc),
        .tick(s_tick)
    );

    tpp_prescale u_l_pre (
        .clk(clk),
        .rst(rst),
        .sel(l_ctrl_q.presc),
        .tick(l_tick)
    );

    tpp_count #(.W(SHORT_W)) u_s_cnt (
        .clk(clk),
        .rst(rst),
        .run(s_ctrl_q.run),
        .tick(s_tick),
        .reload(s_reload_q),
        .count(s_count),
        .tc(s_tc)
    );

    tpp_count #(.W(LONG_W)) u_l_cnt (
        .clk(clk),
        .rst(rst),
        .run(l_ctrl_q.run),
        .tick(l_tick),
        .reload(l_reload_q),
        .count(l_count),
        .tc(l_tc)
    );

    // A software write to a run bit wins over the hardware start or stop of the same cycle.
    always_comb begin
        s_ctrl_d = s_ctrl_q;
        l_ctrl_d = l_ctrl_q;
        if (s_tc && (s_ctrl_q.single || ping_pong)) begin
            s_ctrl_d.run = 1'b0;
        end
        if (l_tc && (l_ctrl_q.single || ping_pong)) begin
            l_ctrl_d.run = 1'b0;
        end
        if (ping_pong && s_tc) begin
            l_ctrl_d.run = 1'b1;
        end
        if (ping_pong && l_tc) begin
            s_ctrl_d.run = 1'b1;
        end
        if (wr_s) begin
            s_ctrl_d.run = pwdata[`TPP_BIT_RUN];
            s_ctrl_d.single = pwdata[`TPP_BIT_SINGLE];
            s_ctrl_d.presc = pwdata[`TPP_BIT_PRE_HI:`TPP_BIT_PRE_LO];
            s_ctrl_d.cap_mask = pwdata[`TPP_BIT_CAPM];
        end
        if (wr_l) begin
            l_ctrl_d.run = pwdata[`TPP_BIT_RUN];
            l_ctrl_d.single = pwdata[`TPP_BIT_SINGLE];
            l_ctrl_d.presc = pwdata[`TPP_BIT_PRE_HI:`TPP_BIT_PRE_LO];
            l_ctrl_d.cap_mask = pwdata[`TPP_BIT_CAPM];
        end
    end

    // Time-out flags: a terminal count in the clearing cycle keeps the flag set.
    always_comb begin
        s_tout_d = s_tout_q;
        l_tout_d = l_tout_q;
        if (wr_s && pwdata[`TPP_BIT_TOUT]) begin
            s_tout_d = 1'b0;
        end
        if (wr_l && pwdata[`TPP_BIT_TOUT]) begin
            l_tout_d = 1'b0;
        end
        if (s_tc) begin
            s_tout_d = 1'b1;
        end
        if (l_tc) begin
            l_tout_d = 1'b1;
        end
    end

    always_comb begin
        aux_d = wr_aux ? pwdata[7:0] : aux_q;
        s_reload_d = s_reload_q;
        l_reload_d = l_reload_q;
        if (wr && idx == `TPP_IDX_SHORT_RELOAD) begin
            s_reload_d = pwdata[SHORT_W-1:0];
        end
        if (wr && idx == `TPP_IDX_LONG_RELOAD) begin
            l_reload_d = pwdata[LONG_W-1:0];
        end
        irq_d = capture_event && s_ctrl_q.cap_mask;
    end

    // Read data is captured in the setup cycle, so the access cycle answers at once.
    always_comb begin
        prdata_d = prdata_q;
        if (setup) begin
            prdata_d = `TPP_RST_BUS;
            case (idx)
                `TPP_IDX_SHORT_CTRL: begin
                    prdata_d[7:0] = {s_ctrl_q.run, s_ctrl_q.single, s_tout_q,
                                     s_ctrl_q.presc, s_ctrl_q.cap_mask, 2'h0};
                end
                `TPP_IDX_AUX_CTRL: begin
                    prdata_d[7:0] = aux_q;
                end
                `TPP_IDX_LONG_CTRL: begin
                    prdata_d[7:0] = {l_ctrl_q.run, l_ctrl_q.single, l_tout_q,
                                     l_ctrl_q.presc, l_ctrl_q.cap_mask, 2'h0};
                end
                `TPP_IDX_SHORT_RELOAD: begin
                    prdata_d[SHORT_W-1:0] = s_reload_q;
                end
                `TPP_IDX_LONG_RELOAD: begin
                    prdata_d[LONG_W-1:0] = l_reload_q;
                end
                `TPP_IDX_COUNT: begin
                    prdata_d[SHORT_W-1:0] = s_count;
                    prdata_d[SHORT_W+LONG_W-1:SHORT_W] = l_count;
                end
                default: begin
                    prdata_d = `TPP_RST_BUS;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ctrl_q <= '0;
            l_ctrl_q <= '0;
            s_tout_q <= 1'b0;
            l_tout_q <= 1'b0;
            aux_q <= `TPP_RST_BYTE;
            s_reload_q <= '0;
            l_reload_q <= '0;
            prdata_q <= `TPP_RST_BUS;
            irq_q <= 1'b0;
        end else begin
            s_ctrl_q <= s_ctrl_d;
            l_ctrl_q <= l_ctrl_d;
            s_tout_q <= s_tout_d;
            l_tout_q <= l_tout_d;
            aux_q <= aux_d;
            s_reload_q <= s_reload_d;
            l_reload_q <= l_reload_d;
            prdata_q <= prdata_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign capture_irq = irq_q;
    assign short_timeout_pulse = s_tc;
    assign long_timeout_pulse = l_tc;

    a_run_reset: assert property (@(posedge clk)
        rst |=> !s_ctrl_q.run && !l_ctrl_q.run)
        else $error("counter running after reset");

    a_run_write: assert property (@(posedge clk) disable iff (rst)
        wr_s |=> s_ctrl_q.run == $past(pwdata[`TPP_BIT_RUN]))
        else $error("run bit did not follow write");

    a_tout_clear: assert property (@(posedge clk) disable iff (rst)
        (wr_s && pwdata[`TPP_BIT_TOUT] && !s_tc) |=> !s_tout_q)
        else $error("time-out flag not cleared by one");

    a_tout_keep: assert property (@(posedge clk) disable iff (rst)
        (s_tout_q && !(wr_s && pwdata[`TPP_BIT_TOUT])) |=> s_tout_q)
        else $error("time-out flag lost without clear");

    a_tc_sets: assert property (@(posedge clk) disable iff (rst)
        (s_tc |=> s_tout_q) and (l_tc |=> l_tout_q))
        else $error("terminal count did not set time-out");

    a_single_stop: assert property (@(posedge clk) disable iff (rst)
        (s_tc && s_ctrl_q.single && !ping_pong && !wr_s) |=> !s_ctrl_q.run)
        else $error("single pass counter kept running");

    a_modulo_runs: assert property (@(posedge clk) disable iff (rst)
        (s_tc && !s_ctrl_q.single && !ping_pong && !wr_s) |=> s_ctrl_q.run)
        else $error("modulo counter stopped at terminal count");

    a_pp_swap: assert property (@(posedge clk) disable iff (rst)
        (ping_pong && s_tc && !l_tc && !wr_s && !wr_l) |=> (l_ctrl_q.run && !s_ctrl_q.run))
        else $error("ping-pong did not hand over to long counter");

    a_cap_mask: assert property (@(posedge clk) disable iff (rst)
        capture_event |=> capture_irq == $past(s_ctrl_q.cap_mask))
        else $error("capture interrupt not gated by mask");

    a_prescale_one: assert property (@(posedge clk) disable iff (rst)
        (s_ctrl_q.presc == `TPP_PRE_DIV1) |-> s_tick)
        else $error("divide by one missed a tick");

    a_long_run_write: assert property (@(posedge clk) disable iff (rst)
        wr_l |=> l_ctrl_q.run == $past(pwdata[`TPP_BIT_RUN]))
        else $error("long run bit did not follow write");

    a_stop_holds: assert property (@(posedge clk) disable iff (rst)
        !s_ctrl_q.run |=> s_count == $past(s_reload_q))
        else $error("stopped counter left its reload value");

    a_run_count: assert property (@(posedge clk) disable iff (rst)
        (s_ctrl_q.run && s_tick && s_count != '0) |=>
            s_count == $past(s_count) - SHORT_W'(1))
        else $error("running counter did not step down on a tick");

    a_tc_reload: assert property (@(posedge clk) disable iff (rst)
        s_tc |=> s_count == $past(s_reload_q))
        else $error("terminal count did not reload the counter");

    a_long_modulo: assert property (@(posedge clk) disable iff (rst)
        (l_tc && !l_ctrl_q.single && !ping_pong && !wr_l) |=> l_ctrl_q.run)
        else $error("modulo long counter stopped at terminal count");

    a_long_tout_clear: assert property (@(posedge clk) disable iff (rst)
        (wr_l && pwdata[`TPP_BIT_TOUT] && !l_tc) |=> !l_tout_q)
        else $error("long time-out flag not cleared by one");

    a_long_tout_keep: assert property (@(posedge clk) disable iff (rst)
        (l_tout_q && !(wr_l && pwdata[`TPP_BIT_TOUT])) |=> l_tout_q)
        else $error("long time-out flag lost without clear");

    a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
        !capture_event |=> !capture_irq)
        else $error("capture interrupt without a capture event");

    a_pp_swap_back: assert property (@(posedge clk) disable iff (rst)
        (ping_pong && l_tc && !s_tc && !wr_s && !wr_l) |=> (s_ctrl_q.run && !l_ctrl_q.run))
        else $error("ping-pong did not hand over to short counter");

    a_long_single_stop: assert property (@(posedge clk) disable iff (rst)
        (l_tc && l_ctrl_q.single && !ping_pong && !wr_l) |=> !l_ctrl_q.run)
        else $error("single pass long counter kept running");
endmodule : tpp_timer_ctrl
`default_nettype wire

// ===== sim/tpp_tb.sv
// Self-checking testbench for the timer control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk;
    logic rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic capture_event;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] lf;
    logic pready;
    logic pslverr;
    logic capture_irq;
    logic st_p;
    logic lt_p;
    logic e;
    int bad_count = 0;
    int comparisons = 0;
    int c;

    tpp_timer_ctrl dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_event(capture_event),
        .capture_irq(capture_irq), .short_timeout_pulse(st_p), .long_timeout_pulse(lt_p));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // The request stays up until pready is seen high; read data is taken at that edge only.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        check(k, 32'h1, "zero wait states");
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // The pulse lasts one cycle, so it is sampled at every edge rather than waited on.
    task automatic wait_tc(input logic lng, input int lim, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while ((lng ? lt_p : st_p) !== 1'b1 && cyc < lim);
    endtask : wait_tc

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        capture_event = 1'b0;
        lf = 32'h50C2FAE0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0, "short ctrl reset");
        apb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0, "long ctrl reset");
        apb(1'b1, 8'h0C, 32'hFF);
        check({31'h0, e}, 32'h1, "unmapped write");
        apb(1'b0, 8'h0C, 32'h0);
        check({e, rd[30:0]}, 32'h80000000, "unmapped read");
        $display("Test reset and map done");
        repeat (8) begin
            lf = lfsr(lf);
            apb(1'b1, 8'h00, {24'h0, lf[7:0] & 8'h5C});
            apb(1'b0, 8'h00, 32'h0);
            check(rd, {24'h0, lf[7:0] & 8'h5C}, "fields");
        end
        $display("Test fields done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'h4 : 32'h0);
            @(posedge clk);
            capture_event <= 1'b1;
            @(posedge clk);
            capture_event <= 1'b0;
            @(posedge clk);
            check({31'h0, capture_irq}, m, "capture irq");
        end
        $display("Test capture done");
        for (int s = 0; s < 4; s++) begin
            lf = lfsr(lf);
            apb(1'b1, 8'h10, {29'h0, lf[2:0]} + 32'h1);
            apb(1'b1, 8'h00, 32'h80 | (s << 3));
            wait_tc(1'b0, 2000, c);
            wait_tc(1'b0, 2000, c);
            check(c, ({29'h0, lf[2:0]} + 32'h2) << s, "period");
            apb(1'b0, 8'h00, 32'h0);
            check(rd & 32'hFC, 32'hA0 | (s << 3), "running");
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b0, 8'h00, 32'h0);
            check(rd, 32'h20, "stopped, flag kept");
            apb(1'b1, 8'h00, 32'h20);
            apb(1'b0, 8'h00, 32'h0);
            check(rd, 32'h0, "flag cleared");
        end
        $display("Test prescale done");
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h00, 32'hC0);
        wait_tc(1'b0, 200, c);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h60, "single pass stop");
        wait_tc(1'b0, 30, c);
        check(c, 30, "no second pass");
        apb(1'b0, 8'h18, 32'h0);
        check(rd, 32'h3, "stopped count holds reload");
        apb(1'b1, 8'h00, 32'h20);
        $display("Test single pass done");
        apb(1'b1, 8'h10, 32'h14);
        apb(1'b1, 8'h14, 32'h14);
        apb(1'b1, 8'h08, 32'h40);
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b1, 8'h04, 32'h0C);
        apb(1'b1, 8'h00, 32'hC0);
        for (int k = 0; k < 2; k++) begin
            wait_tc(k[0], 200, c);
            apb(1'b0, k[0] ? 8'h00 : 8'h08, 32'h0);
            check({31'h0, rd[7]}, 32'h1, "partner started");
            apb(1'b0, k[0] ? 8'h08 : 8'h00, 32'h0);
            check(rd & 32'hE0, 32'h60, "own stopped, flag set");
        end
        $display("Test ping-pong done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0, "short ctrl after second reset");
        apb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h0, "aux ctrl after second reset");
        $display("Test second reset done");
        complete_run();
    end

    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
